//--- common/sbt_pkg.sv
package sbt_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 112;
  localparam int OE_CELL = 108;
  localparam int RST_ONES = 5;
  localparam int SYNC_W = 2;
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // arbitrary identification value
  localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5679;
  typedef enum logic [3:0] {
    SBT_RESET, SBT_IDLE, SBT_SEL_DR, SBT_CAP_DR, SBT_SH_DR, SBT_EX1_DR, SBT_PAU_DR, SBT_EX2_DR,
    SBT_UPD_DR, SBT_SEL_IR, SBT_CAP_IR, SBT_SH_IR, SBT_EX1_IR, SBT_PAU_IR, SBT_EX2_IR, SBT_UPD_IR
  } sbt_state_t;
endpackage

//--- hw/sbt_sync.sv
module sbt_sync
  import sbt_pkg::*;
(
  // clock
  input wire logic mclk,
  input wire logic rst,
  input wire logic rst_val,
  // data
  input wire logic din,
  output logic dout
);
  logic [SYNC_W-1:0] stage;
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage <= {SYNC_W{rst_val}};
    end else begin
      stage <= {stage[SYNC_W-2:0], din};
    end
  end
  assign dout = stage[SYNC_W-1];
endmodule

//--- hw/sbt_tap.sv
// What this block does
// - follows the standard sixteen-state test access controller
// - inputs sampled at test clock rise, data out changes at fall
// - mode select pin with no driver reads as high
// - current instruction picks exactly one data register for the chain
// - serial data enters at msb, leaves from lsb
// - data out enabled only in shift states, else high impedance
// - five high mode-select samples reset the port, memory unaffected
// - power-up reset needs no test clock, data out off
// - three-bit instruction register shifts during instruction scans
// - instruction resets to identification at reset state
// - capture-ir loads 01 into lowest instruction bits
// - bypass is one flip-flop, one test clock delay
// - bypass cleared at every capture-dr, whatever the instruction
// - boundary register captures pins, then shifts
// - pin capture under extest, sample and sample-z
// - spare package cells shift like the others
// - identification instruction captures the fixed 32-bit value
// - sample-z floats memory data outputs until next update-ir
// - under extest, latched cell 108 enables memory data outputs
// - output-enable cell preset high at reset
module sbt_tap
  import sbt_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic rst,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_oe_ext,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // pin ring
  input wire logic [BSR_W-1:0] ring_in,
  output logic [BSR_W-1:0] ring_latch,
  output logic ring_drive,
  output logic q_enable
);
  logic tck_s, tms_s, tdi_s, tck_d;
  logic tms_pin;
  // a floating pin is modelled by the driver's enable: pull-up then wins
  assign tms_pin = tms_oe_ext ? tms : 1'b1;
  sbt_sync u_tck (.mclk(mclk), .rst(rst), .rst_val(1'b0), .din(tck), .dout(tck_s));
  sbt_sync u_tms (.mclk(mclk), .rst(rst), .rst_val(1'b1), .din(tms_pin), .dout(tms_s));
  sbt_sync u_tdi (.mclk(mclk), .rst(rst), .rst_val(1'b1), .din(tdi), .dout(tdi_s));

  logic rise, fall;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  // a tck held low never produces an edge, so the controller stays put
  assign rise = tck_s & ~tck_d;
  assign fall = ~tck_s & tck_d;

  sbt_state_t state, next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      SBT_RESET: next_state = tms_s ? SBT_RESET : SBT_IDLE;
      SBT_IDLE: next_state = tms_s ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_DR: next_state = tms_s ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_CAP_DR: next_state = tms_s ? SBT_EX1_DR : SBT_SH_DR;
      SBT_SH_DR: next_state = tms_s ? SBT_EX1_DR : SBT_SH_DR;
      SBT_EX1_DR: next_state = tms_s ? SBT_UPD_DR : SBT_PAU_DR;
      SBT_PAU_DR: next_state = tms_s ? SBT_EX2_DR : SBT_PAU_DR;
      SBT_EX2_DR: next_state = tms_s ? SBT_UPD_DR : SBT_SH_DR;
      SBT_UPD_DR: next_state = tms_s ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_IR: next_state = tms_s ? SBT_RESET : SBT_CAP_IR;
      SBT_CAP_IR: next_state = tms_s ? SBT_EX1_IR : SBT_SH_IR;
      SBT_SH_IR: next_state = tms_s ? SBT_EX1_IR : SBT_SH_IR;
      SBT_EX1_IR: next_state = tms_s ? SBT_UPD_IR : SBT_PAU_IR;
      SBT_PAU_IR: next_state = tms_s ? SBT_EX2_IR : SBT_PAU_IR;
      SBT_EX2_IR: next_state = tms_s ? SBT_UPD_IR : SBT_SH_IR;
      SBT_UPD_IR: next_state = tms_s ? SBT_SEL_DR : SBT_IDLE;
    endcase
  end

  // power-up reset via rst, no tck needed; five ones walk any state home
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SBT_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end

  logic [IR_W-1:0] ir_sh, ir;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ir_sh <= IR_IDCODE;
      ir <= IR_IDCODE;
    end else if (rise) begin
      unique case (state)
        SBT_RESET: ir <= IR_IDCODE;
        SBT_CAP_IR: ir_sh <= {ir_sh[IR_W-1:2], IR_CAPTURE};
        SBT_SH_IR: ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
        SBT_UPD_IR: ir <= ir_sh;
        default: ;
      endcase
    end
  end

  logic is_ring, is_id;
  // reserved codes fall to bypass so exactly one register is always chosen
  assign is_ring = (ir == IR_EXTEST) || (ir == IR_SAMPLE) || (ir == IR_SAMPLE_Z);
  assign is_id = (ir == IR_IDCODE);

  logic byp;
  logic [ID_W-1:0] id_sh;
  logic [BSR_W-1:0] bsr;
  always_ff @(posedge mclk) begin
    if (rst) begin
      byp <= 1'b0;
      id_sh <= ID_VALUE;
      bsr <= '0;
    end else if (rise) begin
      if (state == SBT_CAP_DR) begin
        byp <= 1'b0;
        if (is_id) begin
          id_sh <= ID_VALUE;
        end
        if (is_ring) begin
          bsr <= ring_in;
        end
      end else if (state == SBT_SH_DR) begin
        if (is_ring) begin
          bsr <= {tdi_s, bsr[BSR_W-1:1]};
        end else if (is_id) begin
          id_sh <= {tdi_s, id_sh[ID_W-1:1]};
        end else begin
          byp <= tdi_s;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ring_latch <= '0;
      ring_latch[OE_CELL] <= 1'b1;
    end else if (rise) begin
      if (state == SBT_RESET) begin
        ring_latch[OE_CELL] <= 1'b1;
      end else if (state == SBT_UPD_DR && is_ring) begin
        ring_latch <= bsr;
      end
    end
  end

  // output gating from settled instruction and latch; memory keeps running
  always_ff @(posedge mclk) begin
    if (rst) begin
      ring_drive <= 1'b0;
      q_enable <= 1'b1;
    end else begin
      ring_drive <= (ir == IR_EXTEST);
      if (ir == IR_SAMPLE_Z) begin
        q_enable <= 1'b0;
      end else if (ir == IR_EXTEST) begin
        q_enable <= ring_latch[OE_CELL];
      end else begin
        q_enable <= 1'b1;
      end
    end
  end

  logic dr_bit;
  always_comb begin
    if (is_ring) begin
      dr_bit = bsr[0];
    end else if (is_id) begin
      dr_bit = id_sh[0];
    end else begin
      dr_bit = byp;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo_oe <= (state == SBT_SH_DR) || (state == SBT_SH_IR);
      tdo <= (state == SBT_SH_IR) ? ir_sh[0] : dr_bit;
    end
  end

  // consecutive tms-high rises, saturating; only feeds the five-edge reset check
  logic [2:0] ones_cnt;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ones_cnt <= '0;
    end else if (rise) begin
      if (!tms_s) begin
        ones_cnt <= '0;
      end else if (ones_cnt != 3'(RST_ONES)) begin
        ones_cnt <= ones_cnt + 3'h1;
      end
    end
  end

  sequence upd_ir_s;
    rise && state == SBT_UPD_IR;
  endsequence

  sequence upd_ring_s;
    rise && state == SBT_UPD_DR && is_ring;
  endsequence

  sequence shift_dr_s;
    rise && state == SBT_SH_DR;
  endsequence

  sequence no_gate_s;
    ir != IR_SAMPLE_Z && ir != IR_EXTEST;
  endsequence

  property tdo_fall_p;
    @(posedge mclk) disable iff (rst) $changed(tdo_oe) |-> $past(fall);
  endproperty
  tdo_edge_a: assert property (tdo_fall_p) else $error("tdo enable changed off a falling tck");

  tdo_shift_a: assert property (@(posedge mclk) disable iff (rst)
    fall |=> tdo_oe == ($past(state) == SBT_SH_DR || $past(state) == SBT_SH_IR))
    else $error("tdo enable wrong for state");

  tdo_ir_a: assert property (@(posedge mclk) disable iff (rst)
    fall && state == SBT_SH_IR |=> tdo == $past(ir_sh[0]))
    else $error("instruction bit not on tdo");

  state_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !rise |=> state == $past(state))
    else $error("controller moved without a tck rise");

  tlr_ir_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_RESET |=> ir == IR_IDCODE)
    else $error("instruction not identification after reset");

  cap_ir_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_CAP_IR |=> ir_sh[1:0] == IR_CAPTURE)
    else $error("capture-ir pattern missing");

  ir_shift_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_SH_IR |=> ir_sh[IR_W-1] == $past(tdi_s))
    else $error("instruction shift did not enter at msb");

  upd_ir_a: assert property (@(posedge mclk) disable iff (rst)
    upd_ir_s |=> ir == $past(ir_sh))
    else $error("instruction not loaded at update-ir");

  tms_reset_a: assert property (@(posedge mclk) disable iff (rst)
    rise && tms_s && state == SBT_SEL_IR |=> state == SBT_RESET)
    else $error("tms high did not reach reset");

  five_ones_a: assert property (@(posedge mclk) disable iff (rst)
    ones_cnt == 3'(RST_ONES) |-> state == SBT_RESET)
    else $error("five tms-high rises did not reset the port");

  byp_clear_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_CAP_DR |=> !byp)
    else $error("bypass not cleared on capture");

  byp_shift_a: assert property (@(posedge mclk) disable iff (rst)
    shift_dr_s and (!is_ring && !is_id) |=> byp == $past(tdi_s))
    else $error("bypass did not take tdi");

  id_cap_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_CAP_DR && is_id |=> id_sh == ID_VALUE)
    else $error("identification value not captured");

  id_shift_a: assert property (@(posedge mclk) disable iff (rst)
    shift_dr_s and is_id |=> id_sh[ID_W-1] == $past(tdi_s))
    else $error("identification shift did not enter at msb");

  ring_shift_a: assert property (@(posedge mclk) disable iff (rst)
    shift_dr_s and is_ring |=> bsr[BSR_W-1] == $past(tdi_s))
    else $error("boundary shift did not enter at msb");

  ring_upd_a: assert property (@(posedge mclk) disable iff (rst)
    upd_ring_s |=> ring_latch == $past(bsr))
    else $error("boundary latch not updated");

  samplez_q_a: assert property (@(posedge mclk) disable iff (rst)
    ir == IR_SAMPLE_Z ##1 ir == IR_SAMPLE_Z |-> !q_enable)
    else $error("outputs not floated under sample-z");

  open_q_a: assert property (@(posedge mclk) disable iff (rst)
    no_gate_s ##1 no_gate_s |-> q_enable)
    else $error("outputs floated without a gating instruction");

  extest_oe_a: assert property (@(posedge mclk) disable iff (rst)
    ir == IR_EXTEST ##1 ir == IR_EXTEST |-> q_enable == $past(ring_latch[OE_CELL]))
    else $error("output enable cell not obeyed");

  extest_drive_a: assert property (@(posedge mclk) disable iff (rst)
    ir == IR_EXTEST ##1 ir == IR_EXTEST |-> ring_drive)
    else $error("ring not driven under extest");

  oe_preset_a: assert property (@(posedge mclk) disable iff (rst)
    rise && state == SBT_RESET |=> ring_latch[OE_CELL])
    else $error("output enable cell not preset");
endmodule

//--- bench/sbt_host.sv
module sbt_host
  import sbt_pkg::*;
(
  // system
  input wire logic mclk,
  // test pins
  output logic tck,
  output logic tms,
  output logic tms_oe_ext,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_oe;
  initial begin
    tck = 1'b0; // idles low between frames
    tms = 1'b1;
    tms_oe_ext = 1'b1;
    tdi = 1'b1;
    last_oe = 1'b0;
  end
  // pins change after the fall, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge mclk);
    q = tdo;
    last_oe = tdo_oe;
    tck = 1'b1;
    repeat (4) @(negedge mclk);
    tck = 1'b0;
  endtask
  // floating pin: the value put on tms is ignored, so drive the opposite
  task automatic tap_reset(input logic float_pin);
    logic q;
    tms_oe_ext = !float_pin;
    repeat (RST_ONES) step(!float_pin, 1'b1, q);
    tms_oe_ext = 1'b1;
    step(1'b0, 1'b1, q);
  endtask
  // walk from idle, shift n bits lsb first, back to idle; only implemented codes sent
  task automatic scan(input logic is_ir, input int n, input logic [BSR_W-1:0] din,
                      output logic [BSR_W-1:0] dout, output logic oe_ok);
    logic q;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b1, q);
    if (is_ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      oe_ok = oe_ok & last_oe;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule

//--- bench/sbt_tap_bench.sv
module sbt_tap_bench
  import sbt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, tck, tms, tms_oe_ext, tdi, tdo, tdo_oe, ring_drive, q_enable, ok;
  logic [BSR_W-1:0] ring_in, ring_latch, got, pre, oe_bit;
  int err_total = 0;
  int comparisons = 0;
  sbt_tap u_dut(.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tms_oe_ext(tms_oe_ext), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_latch(ring_latch), .ring_drive(ring_drive),
    .q_enable(q_enable));
  sbt_host u_host(.mclk(mclk), .tck(tck), .tms(tms), .tms_oe_ext(tms_oe_ext), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [BSR_W-1:0] exp, input logic [BSR_W-1:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_power_up();
    chk("tdo_oe", 1'b0, tdo_oe);
    chk("ring_latch", oe_bit, ring_latch);
    chk("q_enable", 1'b1, q_enable);
    chk("ring_drive", 1'b0, ring_drive);
  endtask
  task automatic t_idcode();
    u_host.scan(1'b0, ID_W, '1, got, ok);
    chk("id", BSR_W'(ID_VALUE), got);
    chk("oe_shift", 1'b1, ok);
    chk("oe_idle", 1'b0, u_host.last_oe);
  endtask
  task automatic t_bypass();
    u_host.scan(1'b1, IR_W, BSR_W'(IR_BYPASS), got, ok);
    chk("ir_cap", IR_CAPTURE, got[1:0]);
    u_host.scan(1'b0, 3, BSR_W'(3'h7), got, ok);
    chk("bypass", BSR_W'(3'h6), got);
    // last bit left a one in the bypass cell; capture must clear it
    u_host.scan(1'b0, 3, BSR_W'(3'h3), got, ok);
    chk("bypass_clr", BSR_W'(3'h6), got);
  endtask
  task automatic t_ring();
    pre = {28{4'h3}} & ~oe_bit;
    u_host.scan(1'b1, IR_W, BSR_W'(IR_SAMPLE), got, ok);
    u_host.scan(1'b0, BSR_W, pre, got, ok);
    chk("ring_cap", {28{4'h5}}, got);
    chk("ring_latch", pre, ring_latch);
    chk("q_enable_s", 1'b1, q_enable);
    u_host.scan(1'b1, IR_W, BSR_W'(IR_EXTEST), got, ok);
    chk("ring_drive", 1'b1, ring_drive);
    chk("q_enable_x", 1'b0, q_enable);
    u_host.scan(1'b0, BSR_W, pre | oe_bit, got, ok);
    chk("ring_cap_x", {28{4'h5}}, got);
    chk("q_enable_x1", 1'b1, q_enable);
    u_host.scan(1'b1, IR_W, BSR_W'(IR_SAMPLE_Z), got, ok);
    chk("q_enable_z", 1'b0, q_enable);
    ring_in = {28{4'ha}};
    u_host.scan(1'b0, BSR_W, pre, got, ok);
    chk("ring_cap_z", {28{4'ha}}, got);
    chk("q_enable_z2", 1'b0, q_enable);
    u_host.scan(1'b1, IR_W, BSR_W'(IR_BYPASS), got, ok);
    chk("q_enable_b", 1'b1, q_enable);
  endtask
  task automatic t_float();
    u_host.tap_reset(1'b1);
    chk("latch_preset", oe_bit, ring_latch & oe_bit);
    t_idcode();
  endtask
  initial begin
    rst = 1'b1;
    ring_in = {28{4'h5}};
    oe_bit = BSR_W'(1) << OE_CELL;
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_power_up();
    u_host.tap_reset(1'b0);
    t_idcode();
    t_bypass();
    t_ring();
    t_float();
    final_report();
  end
  initial begin
    #500000;
    err_total++;
    final_report();
  end
endmodule
